// ### design/thermal_mon_regs.sv
// How it works
// - Filter nibble 000x,001x,011x,111x needs 1,2,3,4 faults in a row.
// - Power-on filter needs one fault; the count never passes four.
// - Filter bit 7 enables clock line timeout; resets off.
// - Filter bit 6 enables data line timeout; resets off.
// - Filter bit 5 masks fault output from the local channel.
// - Setup, rate and limits read at 03-08, written only at 09-0E.
// - Any write to 0F starts one conversion; byte dropped, reads zero.
// - Shared remote addresses follow bank bit: 0 remote 1, 1 remote 2.
// - Remote 2 registers also sit directly at 30-39.
// - High limits and shutdown limits reset to 55; low limits to zero.
// - Hysteresis at 21 resets to 0A, read and written there.
// - Bank bit is bit 3 of primary setup; clear reaches remote 1.
// - First write byte loads the pointer; next byte writes there.
// - Offsets are 10-bit two's complement, low byte left justified.
`timescale 1ns/100ps
`include "thermal_mon_params.svh"
module thermal_mon_regs
    import thermal_mon_pkg::*;
#(
    parameter logic [7:0] PART_ID = 8'hA5, // Arbitrary value
    parameter logic [7:0] MAKER_ID = 8'h5A // Arbitrary value
)
(
    // Device clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Link side, on the serial engine's clock
    input wire logic i_link_clk,
    input wire logic i_link_start,
    input wire logic i_link_byte_valid,
    input wire logic [7:0] i_link_byte,
    input wire logic i_link_rd_req,
    output logic [7:0] o_link_rd_data,
    output logic o_link_rd_valid,
    // Conversion engine
    input wire logic i_meas_valid,
    input wire logic [1:0] i_meas_chan,
    input wire logic [7:0] i_meas_high,
    input wire logic [7:0] i_meas_low,
    input wire logic [1:0] i_diode_open,
    input wire logic i_conv_busy,
    input wire logic i_reg_lock,
    // Controls and alarms
    output logic o_oneshot_start,
    output logic o_scl_timeout_en,
    output logic o_sda_timeout_en,
    output logic [7:0] o_sample_rate,
    output logic [7:0] o_primary_setup,
    output logic [7:0] o_secondary_setup,
    output logic [9:0] o_remote1_offset,
    output logic [9:0] o_remote2_offset,
    output logic o_fault_n,
    output logic o_overtemp_comparator_n
);

    // Returns {above upper, below lower}
    function automatic logic [1:0] limit_state(input logic [15:0] v,
        input logic [15:0] up, input logic [15:0] lo);
        limit_state = {v > up, v < lo};
    endfunction

    // Run length needed before a channel raises the fault
    function automatic logic [2:0] fault_threshold(input logic [3:0] f);
        case (f[3:1])
            3'h1: fault_threshold = 3'h2;
            3'h3: fault_threshold = 3'h3;
            3'h7: fault_threshold = 3'h4;
            default: fault_threshold = 3'h1;
        endcase
    endfunction

    // Link domain state
    logic lrst_meta;
    logic lrst_sync;
    logic first_reg;
    logic ev_ptr_reg;
    logic [7:0] ev_byte_reg;
    logic ev_tgl_reg;
    logic rd_tgl_reg;
    rd_state_t rd_state_reg;
    logic ack_meta;
    logic ack_sync;
    logic ack_seen;
    logic [7:0] link_data_reg;
    logic link_valid_reg;
    // Device domain state
    logic ev_meta;
    logic ev_sync;
    logic ev_seen;
    logic rq_meta;
    logic rq_sync;
    logic rq_seen;
    logic ack_tgl_reg;
    logic [7:0] rd_data_reg;
    logic [7:0] ptr_reg;
    logic [7:0] setup1_reg;
    logic [7:0] rate_reg;
    logic [7:0] hyst_reg;
    logic [7:0] filt_reg;
    logic [7:0] setup2_reg;
    logic [7:0] up_h_reg [0:2];
    logic [7:0] lo_h_reg [0:2];
    logic [7:0] up_l_reg [0:2];
    logic [7:0] lo_l_reg [0:2];
    logic [7:0] shut_reg [0:2];
    logic [7:0] val_h_reg [0:2];
    logic [7:0] val_l_reg [0:2];
    logic [7:0] cor_h_reg [1:2];
    logic [7:0] cor_l_reg [1:2];
    logic [2:0] cnt_reg [0:2];
    logic [2:0] lvl_hi_reg;
    logic [2:0] lvl_lo_reg;
    logic [2:0] sh_reg;
    logic [7:0] flags1_reg;
    logic [7:0] flags2_reg;
    logic oneshot_reg;
    logic fault_n_reg;
    logic ot_n_reg;
    logic ev_edge;
    logic rq_edge;
    logic wr_en;
    logic [1:0] rsel;
    logic [7:0] rd_value;
    logic [2:0] thr;
    logic fault_any;
    logic meas_ok;
    logic [15:0] meas16;

    // Link reset follows the device reset through two flops
    always_ff @(posedge i_link_clk)
    begin
        lrst_meta <= i_rst_n;
        lrst_sync <= lrst_meta;
    end

    // Write frames: first byte is the pointer, later bytes are data
    always_ff @(posedge i_link_clk)
    begin
        if (!lrst_sync)
        begin
            first_reg <= 1'b0;
            ev_ptr_reg <= 1'b0;
            ev_byte_reg <= `RST_ZERO;
            ev_tgl_reg <= 1'b0;
        end
        else if (i_link_byte_valid)
        begin
            ev_ptr_reg <= first_reg | i_link_start;
            ev_byte_reg <= i_link_byte;
            first_reg <= 1'b0;
            ev_tgl_reg <= ~ev_tgl_reg;
        end
        else if (i_link_start)
        begin
            first_reg <= 1'b1;
        end
    end

    // Read request handshake; byte held until the answer toggles back
    always_ff @(posedge i_link_clk)
    begin
        if (!lrst_sync)
        begin
            rd_tgl_reg <= 1'b0;
            rd_state_reg <= RD_IDLE;
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
            ack_seen <= 1'b0;
            link_data_reg <= `RST_ZERO;
            link_valid_reg <= 1'b0;
        end
        else
        begin
            ack_meta <= ack_tgl_reg;
            ack_sync <= ack_meta;
            ack_seen <= ack_sync;
            link_valid_reg <= 1'b0;
            case (rd_state_reg)
                RD_IDLE:
                begin
                    if (i_link_rd_req)
                    begin
                        rd_tgl_reg <= ~rd_tgl_reg;
                        rd_state_reg <= RD_BUSY;
                    end
                end
                RD_BUSY:
                begin
                    if (ack_sync != ack_seen)
                    begin
                        link_data_reg <= rd_data_reg;
                        link_valid_reg <= 1'b1;
                        rd_state_reg <= RD_IDLE;
                    end
                end
                default: rd_state_reg <= RD_IDLE;
            endcase
        end
    end

    // Toggle synchronisers into the device domain
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            ev_meta <= 1'b0;
            ev_sync <= 1'b0;
            ev_seen <= 1'b0;
            rq_meta <= 1'b0;
            rq_sync <= 1'b0;
            rq_seen <= 1'b0;
        end
        else
        begin
            ev_meta <= ev_tgl_reg;
            ev_sync <= ev_meta;
            ev_seen <= ev_sync;
            rq_meta <= rd_tgl_reg;
            rq_sync <= rq_meta;
            rq_seen <= rq_sync;
        end
    end

    // Byte fields are stable by the time their toggle has crossed
    assign ev_edge = ev_sync ^ ev_seen;
    assign rq_edge = rq_sync ^ rq_seen;
    assign wr_en = ev_edge & ~ev_ptr_reg;
    assign rsel = setup1_reg[`B_BANK] ? CH_REMOTE2 : CH_REMOTE1;

    // Pointer register
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            ptr_reg <= `RST_ZERO;
        else if (ev_edge && ev_ptr_reg)
            ptr_reg <= ev_byte_reg;
    end

    // Writable registers; every one of them is lockable
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            setup1_reg <= `RST_ZERO;
            rate_reg <= `RST_RATE;
            hyst_reg <= `RST_HYST;
            filt_reg <= `RST_FILT;
            setup2_reg <= `RST_ZERO;
            for (int i = 0; i < 3; i++)
            begin
                up_h_reg[i] <= `RST_LIMIT;
                shut_reg[i] <= `RST_LIMIT;
                lo_h_reg[i] <= `RST_ZERO;
                up_l_reg[i] <= `RST_ZERO;
                lo_l_reg[i] <= `RST_ZERO;
            end
            for (int i = 1; i < 3; i++)
            begin
                cor_h_reg[i] <= `RST_ZERO;
                cor_l_reg[i] <= `RST_ZERO;
            end
        end
        else if (wr_en && !i_reg_lock)
        begin
            case (ptr_reg)
                `W_SETUP1: setup1_reg <= ev_byte_reg;
                `W_RATE: rate_reg <= ev_byte_reg;
                `W_LOC_UP: up_h_reg[0] <= ev_byte_reg;
                `W_LOC_LO: lo_h_reg[0] <= ev_byte_reg;
                `W_RUP_H: up_h_reg[rsel] <= ev_byte_reg;
                `W_RLO_H: lo_h_reg[rsel] <= ev_byte_reg;
                `A_RCOR_H: cor_h_reg[rsel] <= ev_byte_reg;
                `A_RCOR_L: cor_l_reg[rsel] <= ev_byte_reg & `CORR_LOW_MASK;
                `A_RUP_L: up_l_reg[rsel] <= ev_byte_reg;
                `A_RLO_L: lo_l_reg[rsel] <= ev_byte_reg;
                `A_RSHUT: shut_reg[rsel] <= ev_byte_reg;
                `A_LSHUT: shut_reg[0] <= ev_byte_reg;
                `A_HYST: hyst_reg <= ev_byte_reg;
                `A_FILT: filt_reg <= ev_byte_reg & `FILT_WR_MASK;
                `A_SETUP2: setup2_reg <= ev_byte_reg;
                `A_R2UP_H: up_h_reg[2] <= ev_byte_reg;
                `A_R2LO_H: lo_h_reg[2] <= ev_byte_reg;
                `A_R2COR_H: cor_h_reg[2] <= ev_byte_reg;
                `A_R2COR_L: cor_l_reg[2] <= ev_byte_reg & `CORR_LOW_MASK;
                `A_R2UP_L: up_l_reg[2] <= ev_byte_reg;
                `A_R2LO_L: lo_l_reg[2] <= ev_byte_reg;
                `A_R2SHUT: shut_reg[2] <= ev_byte_reg;
                default: ;
            endcase
        end
    end

    // One-shot start; the written byte is never stored
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            oneshot_reg <= 1'b0;
        else
            oneshot_reg <= wr_en && (ptr_reg == `A_ONESHOT);
    end

    // Read multiplexer; write-only and unmapped addresses read zero
    always_comb
    begin
        case (ptr_reg)
            `A_LOC_VAL: rd_value = val_h_reg[0];
            `A_RV_H: rd_value = val_h_reg[rsel];
            `A_FLAGS1: rd_value = flags1_reg;
            `A_SETUP1: rd_value = setup1_reg;
            `A_RATE: rd_value = rate_reg;
            `A_LOC_UP: rd_value = up_h_reg[0];
            `A_LOC_LO: rd_value = lo_h_reg[0];
            `A_RUP_H: rd_value = up_h_reg[rsel];
            `A_RLO_H: rd_value = lo_h_reg[rsel];
            `A_RV_L: rd_value = val_l_reg[rsel];
            `A_RCOR_H: rd_value = cor_h_reg[rsel];
            `A_RCOR_L: rd_value = cor_l_reg[rsel];
            `A_RUP_L: rd_value = up_l_reg[rsel];
            `A_RLO_L: rd_value = lo_l_reg[rsel];
            `A_RSHUT: rd_value = shut_reg[rsel];
            `A_LSHUT: rd_value = shut_reg[0];
            `A_HYST: rd_value = hyst_reg;
            `A_FILT: rd_value = filt_reg;
            `A_FLAGS2: rd_value = flags2_reg;
            `A_SETUP2: rd_value = setup2_reg;
            `A_R2V_H: rd_value = val_h_reg[2];
            `A_R2UP_H: rd_value = up_h_reg[2];
            `A_R2LO_H: rd_value = lo_h_reg[2];
            `A_R2V_L: rd_value = val_l_reg[2];
            `A_R2COR_H: rd_value = cor_h_reg[2];
            `A_R2COR_L: rd_value = cor_l_reg[2];
            `A_R2UP_L: rd_value = up_l_reg[2];
            `A_R2LO_L: rd_value = lo_l_reg[2];
            `A_R2SHUT: rd_value = shut_reg[2];
            `A_PART: rd_value = PART_ID;
            `A_MAKER: rd_value = MAKER_ID;
            default: rd_value = `RST_ZERO;
        endcase
    end

    // Answer a read; data is held until the next read
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            rd_data_reg <= `RST_ZERO;
            ack_tgl_reg <= 1'b0;
        end
        else if (rq_edge)
        begin
            rd_data_reg <= rd_value;
            ack_tgl_reg <= ~ack_tgl_reg;
        end
    end

    // Measurement results, limit state and fault run counters
    assign meas_ok = i_meas_valid && (i_meas_chan != 2'h3);
    assign meas16 = {i_meas_high,
        (i_meas_chan == CH_LOCAL) ? `RST_ZERO : i_meas_low};
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            for (int i = 0; i < 3; i++)
            begin
                val_h_reg[i] <= `RST_ZERO;
                val_l_reg[i] <= `RST_ZERO;
                cnt_reg[i] <= 3'h0;
            end
            lvl_hi_reg <= 3'h0;
            lvl_lo_reg <= 3'h0;
        end
        else if (meas_ok)
        begin
            val_h_reg[i_meas_chan] <= meas16[15:8];
            val_l_reg[i_meas_chan] <= meas16[7:0];
            {lvl_hi_reg[i_meas_chan], lvl_lo_reg[i_meas_chan]} <=
                limit_state(meas16,
                    {up_h_reg[i_meas_chan], up_l_reg[i_meas_chan]},
                    {lo_h_reg[i_meas_chan], lo_l_reg[i_meas_chan]});
            if (|limit_state(meas16,
                {up_h_reg[i_meas_chan], up_l_reg[i_meas_chan]},
                {lo_h_reg[i_meas_chan], lo_l_reg[i_meas_chan]}))
            begin
                if (cnt_reg[i_meas_chan] != `CNT_MAX)
                    cnt_reg[i_meas_chan] <= 3'(cnt_reg[i_meas_chan] + 3'h1);
            end
            else
                cnt_reg[i_meas_chan] <= 3'h0;
        end
    end

    // Shutdown comparator with hysteresis on the high byte
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            sh_reg <= 3'h0;
        else if (meas_ok)
        begin
            if (i_meas_high > shut_reg[i_meas_chan])
                sh_reg[i_meas_chan] <= 1'b1;
            else if (i_meas_high <
                8'(shut_reg[i_meas_chan] - hyst_reg))
                sh_reg[i_meas_chan] <= 1'b0;
        end
    end

    // Fault output once any unmasked channel reaches its run length
    assign thr = fault_threshold(filt_reg[3:0]);
    assign fault_any = ((cnt_reg[0] >= thr) & ~filt_reg[`B_MASK_LOC])
        | (cnt_reg[1] >= thr) | (cnt_reg[2] >= thr);
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            fault_n_reg <= 1'b1;
            ot_n_reg <= 1'b1;
        end
        else
        begin
            fault_n_reg <= ~fault_any;
            ot_n_reg <= ~|sh_reg;
        end
    end

    // Flags, sticky in flags1 6:2 and flags2 4:2; a new event beats the clear of a status read
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            flags1_reg <= `RST_ZERO;
            flags2_reg <= `RST_ZERO;
        end
        else
        begin
            flags1_reg <= {i_conv_busy,
                {lvl_hi_reg[0], lvl_lo_reg[0], lvl_hi_reg[1],
                 lvl_lo_reg[1], i_diode_open[0]}
                | (flags1_reg[6:2]
                   & {5{~(rq_edge && ptr_reg == `A_FLAGS1)}}),
                sh_reg[1], sh_reg[0]};
            flags2_reg <= {3'h0,
                {lvl_hi_reg[2], lvl_lo_reg[2], i_diode_open[1]}
                | (flags2_reg[4:2]
                   & {3{~(rq_edge && ptr_reg == `A_FLAGS2)}}),
                sh_reg[2], ~fault_n_reg};
        end
    end

    // Outputs straight from flops
    assign o_link_rd_data = link_data_reg;
    assign o_link_rd_valid = link_valid_reg;
    assign o_oneshot_start = oneshot_reg;
    assign o_scl_timeout_en = filt_reg[`B_SCL];
    assign o_sda_timeout_en = filt_reg[`B_SDA];
    assign o_sample_rate = rate_reg;
    assign o_primary_setup = setup1_reg;
    assign o_secondary_setup = setup2_reg;
    assign o_remote1_offset = {cor_h_reg[1], cor_l_reg[1][7:6]};
    assign o_remote2_offset = {cor_h_reg[2], cor_l_reg[2][7:6]};
    assign o_fault_n = fault_n_reg;
    assign o_overtemp_comparator_n = ot_n_reg;

    // Checks
    chk_filter_reset: assert property (@(posedge i_ref_clk)
        $past(!i_rst_n) && i_rst_n |-> filt_reg == `RST_FILT)
        else $error("filter register not one after reset");
    chk_count_bound: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n) cnt_reg[1] <= `CNT_MAX)
        else $error("fault run count above four");
    chk_run_length: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        filt_reg[3:1] == 3'h3 && cnt_reg[1] == 3'h2 && cnt_reg[2] == 3'h0
        && (cnt_reg[0] == 3'h0) |=> o_fault_n)
        else $error("fault raised before three in a row");
    chk_scl_enable: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        wr_en && !i_reg_lock && ptr_reg == `A_FILT
        |=> o_scl_timeout_en == $past(ev_byte_reg[7]))
        else $error("clock timeout enable not taken");
    chk_sda_hold: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        !(wr_en && ptr_reg == `A_FILT) |=> $stable(o_sda_timeout_en))
        else $error("data timeout enable changed without write");
    chk_local_mask: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        filt_reg[5] && cnt_reg[1] == 3'h0 && cnt_reg[2] == 3'h0
        |=> o_fault_n)
        else $error("masked local channel raised fault");
    chk_wo_reads: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        rq_edge && ptr_reg == `W_LOC_UP |=> rd_data_reg == `RST_ZERO)
        else $error("write-only address read non-zero");
    chk_oneshot_pulse: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        wr_en && ptr_reg == `A_ONESHOT
        |=> o_oneshot_start ##1 !o_oneshot_start)
        else $error("one-shot start missing or too long");
    chk_bank_read: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        rq_edge && ptr_reg == `A_RV_H && setup1_reg[3]
        |=> rd_data_reg == $past(val_h_reg[2]))
        else $error("banked read missed remote 2");
    chk_lock_write: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        i_reg_lock |=> $stable(hyst_reg) && $stable(up_h_reg[0]))
        else $error("locked register changed");
    chk_run_restart: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        meas_ok && i_meas_chan == 2'h1 && !(|limit_state(meas16,
        {up_h_reg[1], up_l_reg[1]}, {lo_h_reg[1], lo_l_reg[1]}))
        |=> cnt_reg[1] == 3'h0)
        else $error("run count not restarted");
endmodule

// ### include/thermal_mon_params.svh
`ifndef THERMAL_MON_PARAMS_SVH
`define THERMAL_MON_PARAMS_SVH
// Register addresses (read side, and write side where it differs)
`define A_LOC_VAL 8'h00
`define A_RV_H 8'h01
`define A_FLAGS1 8'h02
`define A_SETUP1 8'h03
`define A_RATE 8'h04
`define A_LOC_UP 8'h05
`define A_LOC_LO 8'h06
`define A_RUP_H 8'h07
`define A_RLO_H 8'h08
`define W_SETUP1 8'h09
`define W_RATE 8'h0A
`define W_LOC_UP 8'h0B
`define W_LOC_LO 8'h0C
`define W_RUP_H 8'h0D
`define W_RLO_H 8'h0E
`define A_ONESHOT 8'h0F
`define A_RV_L 8'h10
`define A_RCOR_H 8'h11
`define A_RCOR_L 8'h12
`define A_RUP_L 8'h13
`define A_RLO_L 8'h14
`define A_RSHUT 8'h19
`define A_LSHUT 8'h20
`define A_HYST 8'h21
`define A_FILT 8'h22
`define A_FLAGS2 8'h23
`define A_SETUP2 8'h24
`define A_R2V_H 8'h30
`define A_R2UP_H 8'h31
`define A_R2LO_H 8'h32
`define A_R2V_L 8'h33
`define A_R2COR_H 8'h34
`define A_R2COR_L 8'h35
`define A_R2UP_L 8'h36
`define A_R2LO_L 8'h37
`define A_R2SHUT 8'h39
`define A_PART 8'h3D
`define A_MAKER 8'h3E
// Power-on values
`define RST_ZERO 8'h00
`define RST_LIMIT 8'h55
`define RST_RATE 8'h07
`define RST_HYST 8'h0A
`define RST_FILT 8'h01
// Field positions and masks
`define B_BANK 3
`define B_SCL 7
`define B_SDA 6
`define B_MASK_LOC 5
`define CORR_LOW_MASK 8'hC0
`define FILT_WR_MASK 8'hEF
`define CNT_MAX 3'h4
`endif

// ### include/thermal_mon_pkg.sv
package thermal_mon_pkg;
    typedef enum logic [1:0] {
        CH_LOCAL = 2'b00,
        CH_REMOTE1 = 2'b01,
        CH_REMOTE2 = 2'b10
    } chan_t;
    typedef enum logic {
        RD_IDLE = 1'b0,
        RD_BUSY = 1'b1
    } rd_state_t;
endpackage

// ### bench/link_host_model.sv
`timescale 1ns/100ps
module link_host_model (
    // Link requests
    output logic o_clk,
    output logic o_start,
    output logic o_valid,
    output logic [7:0] o_byte,
    output logic o_rd_req,
    // Read answer
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_valid
);
    // Clock stands low between frames
    initial
    begin
        o_clk = 1'h0;
        o_start = 1'h0;
        o_valid = 1'h0;
        o_byte = 8'h00;
        o_rd_req = 1'h0;
    end
    // One link cycle; requests change just after the rising edge
    task automatic step(input logic s, v, r, input logic [7:0] b);
        o_clk = 1'h1;
        o_start <= s;
        o_valid <= v;
        o_rd_req <= r;
        o_byte <= v ? b : ~o_byte; // Released line keeps toggling
        #40 o_clk = 1'h0;
        #40;
    endtask
    task automatic idle(input int n);
        repeat (n) step(1'h0, 1'h0, 1'h0, 8'h00);
    endtask
    // Pointer byte first, data byte optional; gaps let bytes cross
    task automatic write(input logic [7:0] p, d, input logic has_d);
        #13.3;
        step(1'h1, 1'h0, 1'h0, 8'h00);
        step(1'h0, 1'h1, 1'h0, p);
        idle(1);
        if (has_d)
            step(1'h0, 1'h1, 1'h0, d);
        idle(3);
    endtask
    // Pointer-only write, then one read; ok stays low without answer
    task automatic read(input logic [7:0] p, output logic [7:0] d,
                        output logic ok);
        write(p, 8'h00, 1'h0);
        step(1'h0, 1'h0, 1'h1, 8'h00);
        ok = 1'h0;
        d = 8'h00;
        for (int i = 0; i < 8 && !ok; i++)
        begin
            idle(1);
            ok = (i_rd_valid === 1'h1);
            d = i_rd_data;
        end
    endtask
endmodule

// ### bench/thermal_monitor_register_map_tb_top.sv
`timescale 1ns/100ps
module thermal_monitor_register_map_tb_top;
    import thermal_mon_pkg::*;
    logic ref_clk, rst_n, lclk, lstart, lvalid, lrd, rd_valid, lock;
    logic meas_valid, shot, scl_en, sda_en, fault_n, ot_n;
    logic [7:0] lbyte, rd_data, rate, meas_high, setup1;
    logic [1:0] meas_chan;
    logic [9:0] off1;
    int mismatches = 0;
    int compares = 0;
    int shots = 0;
    logic [3:0] pat [4] = '{4'h1, 4'h2, 4'h6, 4'hF};
    // Read address and power-on value
    logic [15:0] tab [18] = '{16'h0300, 16'h0407, 16'h0555, 16'h0600,
        16'h0755, 16'h0800, 16'h1100, 16'h1955, 16'h2055, 16'h210A,
        16'h2201, 16'h3155, 16'h3200, 16'h3955, 16'h0F00, 16'h3D3C,
        16'h3EC3, 16'h3F00};
    // Identity parameters are arbitrary values
    thermal_mon_regs #(.PART_ID(8'h3C), .MAKER_ID(8'hC3))
        i_thermal_mon_regs (.i_ref_clk(ref_clk), .i_rst_n(rst_n),
        .i_link_clk(lclk), .i_link_start(lstart),
        .i_link_byte_valid(lvalid), .i_link_byte(lbyte),
        .i_link_rd_req(lrd), .o_link_rd_data(rd_data),
        .o_link_rd_valid(rd_valid), .i_meas_valid(meas_valid),
        .i_meas_chan(meas_chan), .i_meas_high(meas_high),
        .i_meas_low(8'h00), .i_diode_open(2'h0), .i_conv_busy(1'h0),
        .i_reg_lock(lock), .o_oneshot_start(shot),
        .o_scl_timeout_en(scl_en), .o_sda_timeout_en(sda_en),
        .o_sample_rate(rate), .o_primary_setup(setup1),
        .o_secondary_setup(), .o_remote1_offset(off1),
        .o_remote2_offset(), .o_fault_n(fault_n),
        .o_overtemp_comparator_n(ot_n));
    link_host_model i_link_host_model (.o_clk(lclk), .o_start(lstart),
        .o_valid(lvalid), .o_byte(lbyte), .o_rd_req(lrd),
        .i_rd_data(rd_data), .i_rd_valid(rd_valid));
    initial
    begin
        ref_clk = 1'h0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Count conversion start pulses
    always_ff @(posedge ref_clk)
        if (shot === 1'h1)
            shots <= shots + 1;
    task automatic wrap_up();
        if (mismatches == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [9:0] got, exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] p, d);
        i_link_host_model.write(p, d, 1'h1);
    endtask
    // A lost answer ends the run at once
    task automatic rd(input logic [7:0] p, exp);
        logic [7:0] d;
        logic ok;
        i_link_host_model.read(p, d, ok);
        if (!ok)
        begin
            mismatches++;
            wrap_up();
        end
        else
            chk({2'h0, d}, {2'h0, exp});
    endtask
    // One result, then the fixed two-cycle alarm latency settles
    task automatic meas(input logic [1:0] ch, input logic [7:0] hi);
        @(posedge ref_clk);
        meas_valid <= 1'h1;
        meas_chan <= ch;
        meas_high <= hi;
        @(posedge ref_clk);
        meas_valid <= 1'h0;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    initial
    begin
        rst_n = 1'h0;
        lock = 1'h0;
        meas_valid = 1'h0;
        meas_chan = 2'h0;
        meas_high = 8'h00;
        // Link reset needs link edges, so reset spans both
        fork
            repeat (10) @(posedge ref_clk);
            i_link_host_model.idle(4);
        join
        @(posedge ref_clk);
        rst_n <= 1'h1;
        i_link_host_model.idle(3);
        foreach (tab[i])
            rd(tab[i][15:8], tab[i][7:0]);
        chk({9'h0, scl_en}, 10'h000);
        chk({9'h0, sda_en}, 10'h000);
        chk({2'h0, rate}, 10'h007);
        meas(2'h1, 8'h60);
        chk({9'h0, fault_n}, 10'h000);
        chk({9'h0, ot_n}, 10'h000);
        meas(2'h1, 8'h30);
        chk({9'h0, fault_n}, 10'h001);
        chk({9'h0, ot_n}, 10'h001);
        // Each filter pattern, with a broken run first
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h22, {4'hC, pat[k]});
            meas(2'h1, 8'h60);
            meas(2'h1, 8'h30);
            repeat (k) meas(2'h1, 8'h60);
            chk({9'h0, fault_n}, 10'h001);
            meas(2'h1, 8'h60);
            chk({9'h0, fault_n}, 10'h000);
            meas(2'h1, 8'h30);
        end
        chk({9'h0, scl_en}, 10'h001);
        chk({9'h0, sda_en}, 10'h001);
        wr(8'h0B, 8'h60);
        wr(8'h05, 8'h11);
        rd(8'h05, 8'h60);
        rd(8'h0B, 8'h00);
        wr(8'h22, 8'h21);
        meas(2'h0, 8'h70);
        chk({9'h0, fault_n}, 10'h001);
        wr(8'h22, 8'h01);
        meas(2'h0, 8'h70);
        chk({9'h0, fault_n}, 10'h000);
        wr(8'h0F, 8'hA7);
        chk(shots[9:0], 10'h001);
        wr(8'h09, 8'h08);
        chk({2'h0, setup1}, 10'h008);
        wr(8'h0D, 8'h44);
        rd(8'h31, 8'h44);
        meas(2'h2, 8'h20);
        rd(8'h01, 8'h20);
        rd(8'h07, 8'h44);
        wr(8'h09, 8'h00);
        rd(8'h07, 8'h55);
        wr(8'h12, 8'hFF);
        wr(8'h11, 8'h12);
        rd(8'h12, 8'hC0);
        chk(off1, 10'h04B);
        rd(8'h34, 8'h00);
        @(posedge ref_clk);
        lock <= 1'h1;
        wr(8'h21, 8'h33);
        rd(8'h21, 8'h0A);
        @(posedge ref_clk);
        lock <= 1'h0;
        wr(8'h21, 8'h33);
        rd(8'h21, 8'h33);
        wrap_up();
    end
endmodule
